//--- design/epv_pkg.sv
package epv_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Vector layout
  localparam int unsigned DEV_SRC_N = 56;
  localparam logic [15:0] VEC_PIN_POR = 16'hFFFE;
  localparam logic [15:0] VEC_CLKMON = 16'hFFFC;
  localparam logic [15:0] VEC_WATCHDOG = 16'hFFFA;
  localparam logic [7:0] OFS_TRAP = 8'hF8;
  localparam logic [7:0] OFS_SWI = 8'hF6;
  localparam logic [7:0] OFS_HIGH = 8'hF4;
  localparam logic [7:0] OFS_LOW_TOP = 8'hF2;
  localparam logic [7:0] OFS_DEV_TOP = 8'hF0;
  localparam logic [7:0] OFS_SPURIOUS = 8'h80;
  localparam logic [7:0] BASE_LOW_BYTE = 8'h00;
  localparam logic [7:0] DEBUG_BASE = 8'hFF;
  localparam logic [7:0] VBR_RESET = 8'hFF;

  ////////////////////////////////////////////////////////////////////////////
  // Register map
  localparam logic [7:0] ADDR_VBR = 8'h00;
  localparam logic [7:0] ADDR_CTRL = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam int unsigned CTRL_LINK_BIT = 0;
  localparam logic CTRL_LINK_RESET = 1'b0;
  localparam int unsigned STAT_VEC_LSB = 0;
  localparam int unsigned STAT_PEND_BIT = 16;
  localparam int unsigned STAT_SPUR_BIT = 17;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Device sources able to assert without a clock (stop-mode wake-up)
  localparam logic [DEV_SRC_N-1:0] DEV_ASYNC_MASK = {DEV_SRC_N{1'b1}};

  ////////////////////////////////////////////////////////////////////////////
  // Request bundle
  typedef struct packed {
    logic rst_pin_por;
    logic rst_clkmon;
    logic rst_watchdog;
    logic trap;
    logic swi_or_debug;
    logic high_pin;
    logic link_err;
    logic low_pin;
    logic link_irq;
    logic low_mask;
    logic high_mask;
    logic [DEV_SRC_N-1:0] dev;
  } epv_req_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_HOLD = 2'b10
  } epv_state_t;

endpackage

//--- design/epv_vector_unit.sv
module epv_vector_unit
  import epv_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Exception requests and CPU mask flags
  input wire epv_req_t req_in,
  input wire logic [DEV_SRC_N-1:0] dev_local_en,
  input wire logic debug_active,
  // CPU vector fetch
  input wire logic vec_req,
  output logic vec_valid,
  output logic [15:0] vec_addr,
  output logic irq_low_pending,
  output logic irq_high_pending,
  // Stop-mode wake-up
  output logic wake_stop,
  output logic wake_resume_only,
  // AXI4-Lite slave
  input wire logic [7:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [7:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready
);

  ////////////////////////////////////////////////////////////////////////////
  // Synchroniser and registers
  epv_req_t sync_a;
  epv_req_t sync_b;
  logic [DEV_SRC_N-1:0] en_a;
  logic [DEV_SRC_N-1:0] en_b;
  logic [7:0] vbr;
  logic link_sel;
  logic last_spurious;
  epv_state_t state;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync_a <= '0;
      sync_b <= '0;
      en_a <= '0;
      en_b <= '0;
    end else begin
      sync_a <= req_in;
      sync_b <= sync_a;
      en_a <= dev_local_en;
      en_b <= en_a;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Priority decoding
  logic high_src;
  logic low_src;
  logic high_ok;
  logic nonlow_pend;
  logic low_ok;
  logic [DEV_SRC_N-1:0] dev_q;
  logic [7:0] base_hi;
  logic [15:0] next_vec;
  logic next_spur;

  assign high_src = link_sel ? sync_b.link_err : sync_b.high_pin;
  assign low_src = link_sel ? sync_b.link_irq : sync_b.low_pin;
  assign high_ok = high_src & ~sync_b.high_mask;
  assign nonlow_pend = sync_b.trap | sync_b.swi_or_debug | high_ok;
  assign low_ok = ~sync_b.low_mask & ~nonlow_pend;
  assign base_hi = debug_active ? DEBUG_BASE : vbr;

  genvar gi;
  generate
    for (gi = 0; gi < DEV_SRC_N; gi++) begin : g_dev
      assign dev_q[gi] = sync_b.dev[gi] & en_b[gi] & low_ok;
    end
  endgenerate

  always_comb begin
    next_vec = {base_hi, OFS_SPURIOUS};
    next_spur = 1'b1;
    // Index 0 sits at the top of the device range; lowest index wins
    for (int i = DEV_SRC_N - 1; i >= 0; i--) begin
      if (dev_q[i]) begin
        next_vec = {base_hi, OFS_DEV_TOP - 8'(2 * i)};
        next_spur = 1'b0;
      end
    end
    if (low_src && low_ok) begin
      next_vec = {base_hi, OFS_LOW_TOP};
      next_spur = 1'b0;
    end
    if (high_ok) begin
      next_vec = {base_hi, OFS_HIGH};
      next_spur = 1'b0;
    end
    if (sync_b.swi_or_debug) begin
      next_vec = {base_hi, OFS_SWI};
      next_spur = 1'b0;
    end
    if (sync_b.trap) begin
      next_vec = {base_hi, OFS_TRAP};
      next_spur = 1'b0;
    end
    if (sync_b.rst_watchdog) begin
      next_vec = VEC_WATCHDOG;
      next_spur = 1'b0;
    end
    if (sync_b.rst_clkmon) begin
      next_vec = VEC_CLKMON;
      next_spur = 1'b0;
    end
    if (sync_b.rst_pin_por) begin
      next_vec = VEC_PIN_POR;
      next_spur = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Vector fetch handshake
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= ST_IDLE;
      vec_valid <= 1'b0;
      vec_addr <= 16'h0000;
      last_spurious <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (vec_req) begin
            vec_addr <= next_vec;
            last_spurious <= next_spur;
            vec_valid <= 1'b1;
            state <= ST_HOLD;
          end
        end
        ST_HOLD: begin
          // Vector frozen until the CPU drops its request
          if (!vec_req) begin
            vec_valid <= 1'b0;
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
          vec_valid <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_low_pending <= 1'b0;
      irq_high_pending <= 1'b0;
    end else begin
      irq_low_pending <= ((low_src & low_ok) | (|dev_q));
      irq_high_pending <= nonlow_pend;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Stop-mode wake-up: pure gates, since the clock is off in stop
  logic wake_high_raw;
  logic wake_low_raw;

  assign wake_high_raw = req_in.high_pin | req_in.link_err;
  assign wake_low_raw = ~req_in.low_mask & (req_in.low_pin | req_in.link_irq |
                        (|(req_in.dev & dev_local_en & DEV_ASYNC_MASK)));
  assign wake_stop = wake_high_raw | wake_low_raw;
  // Source must stay up until the resumed instruction runs
  assign wake_resume_only = wake_high_raw & req_in.high_mask & ~wake_low_raw;

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;

  assign s_awready = ~aw_held & ~s_bvalid;
  assign s_wready = ~w_held & ~s_bvalid;
  assign s_arready = ~s_rvalid;
  assign do_write = aw_held & w_held & ~s_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      s_bvalid <= 1'b0;
      s_bresp <= RESP_OKAY;
    end else begin
      if (s_awvalid && s_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_awaddr;
      end
      if (s_wvalid && s_wready) begin
        w_held <= 1'b1;
        w_data <= s_wdata;
        w_strb <= s_wstrb;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_bvalid <= 1'b1;
        if (aw_addr == ADDR_VBR || aw_addr == ADDR_CTRL || aw_addr == ADDR_STATUS) begin
          s_bresp <= RESP_OKAY;
        end else begin
          s_bresp <= RESP_SLVERR;
        end
      end else if (s_bvalid && s_bready) begin
        s_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      vbr <= VBR_RESET;
      link_sel <= CTRL_LINK_RESET;
    end else if (do_write && w_strb[0]) begin
      if (aw_addr == ADDR_VBR) begin
        vbr <= w_data[7:0];
      end else if (aw_addr == ADDR_CTRL) begin
        link_sel <= w_data[CTRL_LINK_BIT];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_rvalid <= 1'b0;
      s_rdata <= 32'h00000000;
      s_rresp <= RESP_OKAY;
    end else if (s_arvalid && s_arready) begin
      s_rvalid <= 1'b1;
      s_rresp <= RESP_OKAY;
      s_rdata <= 32'h00000000;
      if (s_araddr == ADDR_VBR) begin
        s_rdata[7:0] <= vbr;
      end else if (s_araddr == ADDR_CTRL) begin
        s_rdata[CTRL_LINK_BIT] <= link_sel;
      end else if (s_araddr == ADDR_STATUS) begin
        s_rdata[STAT_VEC_LSB +: 16] <= vec_addr;
        s_rdata[STAT_PEND_BIT] <= irq_low_pending | irq_high_pending;
        s_rdata[STAT_SPUR_BIT] <= last_spurious;
      end else begin
        s_rresp <= RESP_SLVERR;
      end
    end else if (s_rvalid && s_rready) begin
      s_rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_vector_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    vec_valid && vec_req |=> vec_valid && $stable(vec_addr))
    else $error("vector changed during fetch");

  a_vector_capture: assert property (@(posedge aclk) disable iff (!aresetn)
    state == ST_IDLE && vec_req |=> vec_valid && vec_addr == $past(next_vec))
    else $error("vector not taken from pending set");

  a_reset_top: assert property (@(posedge aclk) disable iff (!aresetn)
    sync_b.rst_pin_por |-> next_vec == VEC_PIN_POR)
    else $error("pin reset vector lost priority");

  a_spurious_vec: assert property (@(posedge aclk) disable iff (!aresetn)
    next_spur |-> next_vec[7:0] == OFS_SPURIOUS && next_vec[15:8] == base_hi &&
      !(|dev_q) && !nonlow_pend && !(low_src && low_ok) && !sync_b.rst_pin_por &&
      !sync_b.rst_clkmon && !sync_b.rst_watchdog)
    else $error("spurious vector wrong");

  a_debug_base: assert property (@(posedge aclk) disable iff (!aresetn)
    debug_active |-> next_vec[15:8] == DEBUG_BASE)
    else $error("debug base not forced");

  a_low_masked: assert property (@(posedge aclk) disable iff (!aresetn)
    sync_b.low_mask |-> !(|dev_q) && next_vec[7:0] != OFS_LOW_TOP)
    else $error("low request passed its mask");

  a_low_below: assert property (@(posedge aclk) disable iff (!aresetn)
    sync_b.trap && !sync_b.rst_pin_por && !sync_b.rst_clkmon && !sync_b.rst_watchdog
    |-> next_vec == {base_hi, OFS_TRAP})
    else $error("trap lost to lower source");

  a_high_wake: assert property (@(posedge aclk) disable iff (!aresetn)
    req_in.high_pin |-> wake_stop)
    else $error("high request did not wake");

  a_vbr_reset: assert property (@(posedge aclk)
    !aresetn |=> vbr == VBR_RESET)
    else $error("base register not reset to FF");

  // A trap, SWI/debug or unmasked high request keeps the low pending flag down; reset requests do not
  a_low_blocked: assert property (@(posedge aclk) disable iff (!aresetn)
    nonlow_pend |=> !irq_low_pending)
    else $error("low request pending beside a higher one");

  a_pending_mask: assert property (@(posedge aclk) disable iff (!aresetn)
    sync_b.low_mask |=> !irq_low_pending)
    else $error("low request pending under its mask");

  a_high_preempt: assert property (@(posedge aclk) disable iff (!aresetn)
    high_ok && !sync_b.trap && !sync_b.swi_or_debug && !sync_b.rst_pin_por &&
    !sync_b.rst_clkmon && !sync_b.rst_watchdog |-> next_vec == {base_hi, OFS_HIGH})
    else $error("high request did not win over low ones");

  a_dev_order: assert property (@(posedge aclk) disable iff (!aresetn)
    dev_q[0] && !low_src && !sync_b.rst_pin_por && !sync_b.rst_clkmon &&
    !sync_b.rst_watchdog |-> next_vec == {base_hi, OFS_DEV_TOP})
    else $error("top device source not vectored first");

  a_link_select: assert property (@(posedge aclk) disable iff (!aresetn)
    link_sel && sync_b.high_pin && !sync_b.link_err |-> !high_ok)
    else $error("high pin used while link present");

  a_vec_drop: assert property (@(posedge aclk) disable iff (!aresetn)
    vec_valid && !vec_req |=> !vec_valid)
    else $error("vector kept after fetch ended");

  // Wake path is gates only, so these hold in the same cycle
  a_low_wake_mask: assert property (@(posedge aclk) disable iff (!aresetn)
    req_in.low_mask && !req_in.high_pin && !req_in.link_err |-> !wake_stop)
    else $error("masked low request woke the core");

  a_resume_only: assert property (@(posedge aclk) disable iff (!aresetn)
    wake_resume_only |-> wake_stop && req_in.high_mask)
    else $error("resume without a masked high wake");

endmodule

//--- sim/epv_cpu_model.sv
module epv_cpu_model (
  // Clock
  input wire logic aclk,
  // Vector fetch
  output logic vec_req,
  input wire logic vec_valid,
  input wire logic [15:0] vec_addr
);
  timeunit 1ns;
  timeprecision 1ps;

  initial vec_req = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // Holds the ask until the vector shows, then hold more cycles (slow core)
  task automatic fetch(input int hold, output logic [15:0] first, output logic [15:0] last,
                       output logic ok);
    int n;
    n = 0;
    @(posedge aclk);
    vec_req <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
    end while (vec_valid !== 1'b1 && n < 40);
    ok = vec_valid;
    first = vec_addr;
    repeat (hold) @(posedge aclk);
    last = vec_addr;
    vec_req <= 1'b0;
    @(posedge aclk);
  endtask
endmodule

//--- sim/exception_priority_vectoring_tb_top.sv
module exception_priority_vectoring_tb_top
  import epv_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    logic [10:0] top;
    logic [DEV_SRC_N-1:0] dev;
    logic [15:0] exp;
  } epv_row_t;

  logic aclk, aresetn, debug_active, vec_req, vec_valid, ok;
  logic irq_low_pending, irq_high_pending, wake_stop, wake_resume_only;
  epv_req_t req_in;
  logic [DEV_SRC_N-1:0] dev_local_en;
  logic [15:0] vec_addr, va, vb;
  logic [7:0] s_awaddr, s_araddr;
  logic [31:0] s_wdata, s_rdata, rd;
  logic [3:0] s_wstrb;
  logic [1:0] s_bresp, s_rresp, rr;
  logic s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
  logic s_arvalid, s_arready, s_rvalid, s_rready;
  int failures = 0;
  int n_tests = 0;
  int cyc = 0;
  epv_row_t rows [14] = '{
    {11'h7FC, 56'h0, 16'hFFFE}, {11'h3FC, 56'h0, 16'hFFFC}, {11'h1FC, 56'h0, 16'hFFFA},
    {11'h0FC, 56'h0, 16'hFFF8}, {11'h07C, 56'h0, 16'hFFF6}, {11'h038, 56'h1, 16'hFFF4},
    {11'h008, 56'h1, 16'hFFF2}, {11'h000, 56'h88, 16'hFFEA},
    {11'h000, 56'h80000000000000, 16'hFF82}, {11'h000, 56'h0, 16'hFF80},
    {11'h00A, 56'h1, 16'hFF80}, {11'h029, 56'h0, 16'hFFF2}, {11'h021, 56'h0, 16'hFF80},
    {11'h010, 56'h0, 16'hFF80}};

  epv_vector_unit u_dut (.aclk(aclk), .aresetn(aresetn), .req_in(req_in),
    .dev_local_en(dev_local_en), .debug_active(debug_active), .vec_req(vec_req),
    .vec_valid(vec_valid), .vec_addr(vec_addr), .irq_low_pending(irq_low_pending),
    .irq_high_pending(irq_high_pending), .wake_stop(wake_stop),
    .wake_resume_only(wake_resume_only), .s_awaddr(s_awaddr), .s_awvalid(s_awvalid),
    .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid),
    .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
    .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready), .s_rdata(s_rdata),
    .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready));

  epv_cpu_model u_cpu (.aclk(aclk), .vec_req(vec_req), .vec_valid(vec_valid),
    .vec_addr(vec_addr));

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // Generous ceiling: the whole run needs well under a thousand cycles
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      conclude();
    end
  end

  task automatic conclude();
    $display("checks %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge aclk);
    s_awaddr <= a;
    s_wdata <= d;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_awready) s_awvalid <= 1'b0;
      if (s_wready) s_wvalid <= 1'b0;
    end while (s_bvalid !== 1'b1 && n < 40);
    rr = s_bresp;
    chk("bvalid", 32'h1, 32'(s_bvalid));
    s_bready <= 1'b0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_arready) s_arvalid <= 1'b0;
    end while (s_rvalid !== 1'b1 && n < 40);
    rd = s_rdata;
    s_rready <= 1'b0;
    chk("rvalid", 32'h1, 32'(s_rvalid));
    chk("rresp", 32'(er), 32'(s_rresp));
    chk("rdata", e, rd);
  endtask

  // Sources hold their request through the fetch
  task automatic vec_chk(input logic [10:0] t, input logic [55:0] d, input logic [15:0] e);
    @(posedge aclk);
    req_in <= {t, d};
    repeat (3) @(posedge aclk);
    u_cpu.fetch(0, va, vb, ok);
    chk("vec_valid", 32'h1, 32'(ok));
    chk("vec_addr", 32'(e), 32'(va));
  endtask

  task automatic wk(input logic [10:0] t, input logic [55:0] d, input logic [55:0] en,
                    input logic w, input logic r);
    @(posedge aclk);
    req_in <= {t, d};
    dev_local_en <= en;
    #1;
    chk("wake_stop", 32'(w), 32'(wake_stop));
    chk("wake_resume_only", 32'(r), 32'(wake_resume_only));
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    aresetn = 1'b0;
    req_in = '0;
    dev_local_en = '1;
    debug_active = 1'b0;
    {s_awaddr, s_araddr, s_wdata} = '0;
    s_wstrb = 4'hF;
    {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = '0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rdc(ADDR_VBR, 32'hFF, RESP_OKAY);
    rdc(ADDR_CTRL, 32'h0, RESP_OKAY);
    rdc(8'h40, 32'h0, RESP_SLVERR);
    axi_wr(8'h40, 32'h1);
    chk("bresp", 32'(RESP_SLVERR), 32'(rr));
    foreach (rows[i]) vec_chk(rows[i].top, rows[i].dev, rows[i].exp);
    // Trap blocks the low request; then both vanish before the ask
    @(posedge aclk);
    req_in <= {11'h088, 56'h0};
    repeat (4) @(posedge aclk);
    #1;
    chk("irq_high_pending", 32'h1, 32'(irq_high_pending));
    chk("irq_low_pending", 32'h0, 32'(irq_low_pending));
    vec_chk(11'h000, 56'h0, 16'hFF80);
    // Slow core; a reset request lands while the vector is out
    @(posedge aclk);
    req_in <= {11'h008, 56'h0};
    repeat (3) @(posedge aclk);
    fork
      u_cpu.fetch(6, va, vb, ok);
      begin
        repeat (4) @(posedge aclk);
        req_in <= {11'h400, 56'h0};
      end
    join
    chk("vec_first", 32'hFFF2, 32'(va));
    chk("vec_last", 32'hFFF2, 32'(vb));
    vec_chk(11'h408, 56'h0, 16'hFFFE);
    axi_wr(ADDR_VBR, 32'h12);
    chk("bresp", 32'(RESP_OKAY), 32'(rr));
    rdc(ADDR_VBR, 32'h12, RESP_OKAY);
    vec_chk(11'h008, 56'h0, 16'h12F2);
    rdc(ADDR_STATUS, 32'h000112F2, RESP_OKAY);
    chk("status", 32'h12F2, {16'h0, rd[15:0]});
    vec_chk(11'h000, 56'h0, 16'h1280);
    vec_chk(11'h400, 56'h0, 16'hFFFE);
    @(posedge aclk);
    debug_active <= 1'b1;
    vec_chk(11'h008, 56'h0, 16'hFFF2);
    @(posedge aclk);
    debug_active <= 1'b0;
    axi_wr(ADDR_CTRL, 32'h1);
    vec_chk(11'h010, 56'h0, 16'h12F4);
    vec_chk(11'h004, 56'h0, 16'h12F2);
    vec_chk(11'h028, 56'h0, 16'h1280);
    wk(11'h008, 56'h0, '1, 1'b1, 1'b0);
    wk(11'h00A, 56'h1, '1, 1'b0, 1'b0);
    wk(11'h021, 56'h0, '1, 1'b1, 1'b1);
    wk(11'h020, 56'h0, '1, 1'b1, 1'b0);
    wk(11'h011, 56'h0, '1, 1'b1, 1'b1);
    wk(11'h000, 56'h1, '1, 1'b1, 1'b0);
    wk(11'h000, 56'h1, '0, 1'b0, 1'b0);
    vec_chk(11'h000, 56'h1, 16'h1280);
    // Second reset: wake path must answer with no clocked state
    @(posedge aclk);
    dev_local_en <= '1;
    req_in <= {11'h008, 56'h0};
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    #1;
    chk("wake_stop", 32'h1, 32'(wake_stop));
    @(posedge aclk);
    aresetn <= 1'b1;
    rdc(ADDR_VBR, 32'hFF, RESP_OKAY);
    vec_chk(11'h008, 56'h0, 16'hFFF2);
    conclude();
  end
endmodule
